// File: design/oad_decode.sv
// Operand addressing decoder: mode decode, code word fetch, register shaping
// Operation
// - Seven source modes, four destination modes
// - Twenty-bit addresses reach the whole space
// - Register mode uses register contents directly
// - Indexed address is register plus index
// - Symbolic is indexed from program counter
// - Absolute is indexed from zero status base
// - Source indirect uses register as pointer
// - Autoincrement adds one, two or four
// - Immediate takes constant from next word
// - Any source pairs with any destination
// - Register mode valid for both operands
// - Byte write clears destination bits 19:8
// - Word write clears destination bits 19:16
// - Address-word moves all twenty bits
// - Source register written back only by autoincrement
// - Sign extend of a byte copies bit 7 upward
// - Length and byte bits 01 select twenty-bit
// - Second generator yields 0, 1, 2, minus one
// - First generator: absolute zero, 4, 8
//
// The strobed register port and the placing of the registers were left to the implementer.
`default_nettype none
module oad_decode (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic pc_load_i,
   input wire logic [19:0] pc_load_val_i,
   input wire logic start_i,
   input wire logic ext_valid_i,
   input wire logic [15:0] ext_word_i,
   input wire logic [3:0] source_register_i,
   input wire logic [1:0] source_mode_field_i,
   input wire logic [3:0] dest_register_i,
   input wire logic dest_mode_i,
   input wire logic byte_word_i,
   input wire logic [19:0] src_reg_val_i,
   input wire logic [19:0] dst_reg_val_i,
   input wire logic word_valid_i,
   input wire logic [15:0] word_i,
   input wire logic wb_we_i,
   input wire logic [19:0] wb_data_i,
   input wire logic sign_extend_op_i,
   output logic busy_o,
   output logic word_req_o,
   output logic [19:0] program_counter_o,
   output logic done_o,
   output logic [1:0] width_o,
   output logic [1:0] src_kind_o,
   output logic [19:0] src_addr_o,
   output logic [19:0] src_val_o,
   output logic [1:0] dst_kind_o,
   output logic [19:0] dst_addr_o,
   output logic inc_we_o,
   output logic [3:0] inc_reg_o,
   output logic [19:0] inc_val_o,
   output logic wb_we_o,
   output logic [3:0] wb_reg_o,
   output logic [19:0] wb_data_o
);
   oad_pkg::oad_state_e state_r, state_nxt;
   oad_pkg::oad_width_e width_r;
   logic ctrl_en_r;
   logic [15:0] count_r;
   logic [31:0] rdata_r;
   logic [19:0] pc_r, pc_nxt, pc_start_r;
   logic [2:0] words_r;
   logic ext_r, dmode_r, check_r;
   logic [3:0] sreg_r, dreg_r, src_hi_r, dst_hi_r;
   logic [1:0] smode_r;
   logic [19:0] sval_r, dval_r, spc_r, dpc_r;
   logic [15:0] sword_r, dword_r;
   logic word_take, start_take, need_src, need_dst, cg_hit;
   logic [19:0] cg_val, src_shaped, wb_shaped, src_idx, dst_idx, src_base, dst_base;
   logic [19:0] step, src_imm;
   oad_pkg::oad_width_e width_in;
   oad_pkg::oad_kind_e skind, dkind;
   logic [19:0] saddr, sval;

   // Index combining: extension bits on top, otherwise a sign-extended word
   function automatic logic [19:0] index_of(input logic ext, input logic [3:0] hi,
                                           input logic [15:0] w);
      return ext ? {hi, w} : {{4{w[15]}}, w};
   endfunction

   // Word-level decode of the capture inputs and of the held fields
   assign width_in = oad_pkg::width_of(ext_valid_i, ext_word_i[oad_pkg::EXT_AL],
                                       byte_word_i);
   // A start during the check cycle would overwrite the held fields, so it is refused
   assign start_take = start_i && ctrl_en_r && (state_r == oad_pkg::OAD_S_IDLE) && !check_r;
   assign word_take = word_req_o && word_valid_i;
   // Indexed and immediate need a word; the generators do not
   assign need_src = ((smode_r == oad_pkg::SM_IDX) && (sreg_r != oad_pkg::REG_CG2)) ||
                     ((smode_r == oad_pkg::SM_INC) && (sreg_r == oad_pkg::REG_PC));
   assign need_dst = dmode_r;

   oad_const_gen u_cg (
      .reg_i(sreg_r),
      .mode_i(smode_r),
      .width_i(width_r),
      .hit_o(cg_hit),
      .value_o(cg_val)
   );

   oad_reg_format u_src_fmt (
      .data_i(sval_r),
      .width_i(width_r),
      .sxt_i(1'b0),
      .data_o(src_shaped)
   );

   oad_reg_format u_wb_fmt (
      .data_i(wb_data_i),
      .width_i(width_r),
      .sxt_i(sign_extend_op_i),
      .data_o(wb_shaped)
   );

   // Base selection: program counter for symbolic, zero for absolute
   assign src_base = (sreg_r == oad_pkg::REG_PC) ? spc_r :
                     (sreg_r == oad_pkg::REG_SR) ? oad_pkg::K_ZERO : sval_r;
   assign dst_base = (dreg_r == oad_pkg::REG_PC) ? dpc_r :
                     (dreg_r == oad_pkg::REG_SR) ? oad_pkg::K_ZERO : dval_r;
   // Addition wraps inside the twenty-bit space
   assign src_idx = src_base + index_of(ext_r, src_hi_r, sword_r);
   assign dst_idx = dst_base + index_of(ext_r, dst_hi_r, dword_r);
   assign src_imm = ext_r ? {src_hi_r, sword_r} : {4'h0, sword_r};
   assign step = (width_r == oad_pkg::OAD_W_BYTE) ? oad_pkg::STEP_B :
                 (width_r == oad_pkg::OAD_W_WORD) ? oad_pkg::STEP_W : oad_pkg::STEP_A;

   // Source operand location, generators checked first
   assign skind = cg_hit ? oad_pkg::OAD_K_CONST :
                  (smode_r == oad_pkg::SM_REG) ? oad_pkg::OAD_K_REG :
                  (smode_r == oad_pkg::SM_INC && sreg_r == oad_pkg::REG_PC) ?
                  oad_pkg::OAD_K_CONST : oad_pkg::OAD_K_MEM;
   assign saddr = (smode_r == oad_pkg::SM_IDX) ? src_idx : sval_r;
   assign sval = cg_hit ? cg_val : (smode_r == oad_pkg::SM_REG) ? src_shaped : src_imm;
   // Destination is independent of the source choice
   assign dkind = dmode_r ? oad_pkg::OAD_K_MEM : oad_pkg::OAD_K_REG;

   // A one-cycle check state after capture keeps the word decode on held fields
   oad_pkg::oad_state_e route_nxt;
   assign route_nxt = need_src ? oad_pkg::OAD_S_SRCW :
                      need_dst ? oad_pkg::OAD_S_DSTW : oad_pkg::OAD_S_IDLE;

   // Sequencer: check, then source word, then destination word, then finish
   always_comb
   begin
      state_nxt = state_r;
      if (check_r)
         state_nxt = (route_nxt != oad_pkg::OAD_S_IDLE) ? route_nxt : oad_pkg::OAD_S_FIN;
      else
         case (state_r)
            oad_pkg::OAD_S_FIN:
               state_nxt = oad_pkg::OAD_S_IDLE;
            oad_pkg::OAD_S_SRCW:
               if (word_take)
                  state_nxt = need_dst ? oad_pkg::OAD_S_DSTW : oad_pkg::OAD_S_FIN;
            oad_pkg::OAD_S_DSTW:
               if (word_take)
                  state_nxt = oad_pkg::OAD_S_FIN;
            default:
               state_nxt = state_r;
         endcase
   end

   // Program counter: one word per instruction, extension and code word
   localparam logic [19:0] PC_TWO = 20'h00004;
   assign pc_nxt = pc_load_i ? pc_load_val_i :
                   start_take ? pc_r + (ext_valid_i ? PC_TWO : oad_pkg::PC_STEP) :
                   word_take ? pc_r + oad_pkg::PC_STEP : pc_r;
   assign program_counter_o = pc_r;

   // Control state and phase
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_r <= oad_pkg::OAD_S_IDLE;
         check_r <= 1'b0;
         pc_r <= oad_pkg::K_ZERO;
         words_r <= 3'h0;
      end
      else
      begin
         check_r <= start_take;
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         words_r <= start_take ? (ext_valid_i ? 3'h2 : 3'h1) : words_r + {2'h0, word_take};
      end
   end

   // Field capture at instruction start
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         {ext_r, dmode_r, sreg_r, dreg_r, smode_r} <= 12'h000;
         {src_hi_r, dst_hi_r, sval_r, dval_r} <= 48'h0;
         width_r <= oad_pkg::OAD_W_WORD;
         pc_start_r <= oad_pkg::K_ZERO;
      end
      else if (start_take)
      begin
         ext_r <= ext_valid_i;
         dmode_r <= dest_mode_i;
         sreg_r <= source_register_i;
         dreg_r <= dest_register_i;
         smode_r <= source_mode_field_i;
         src_hi_r <= ext_word_i[oad_pkg::EXT_SRC_HI:oad_pkg::EXT_SRC_LO];
         dst_hi_r <= ext_word_i[oad_pkg::EXT_DST_HI:oad_pkg::EXT_DST_LO];
         sval_r <= src_reg_val_i;
         dval_r <= dst_reg_val_i;
         width_r <= width_in;
         pc_start_r <= pc_r;
      end
   end

   // Code word capture; the base is the address of the word itself
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         {sword_r, dword_r} <= 32'h0;
         {spc_r, dpc_r} <= 40'h0;
      end
      else if (word_take && state_r == oad_pkg::OAD_S_SRCW)
      begin
         sword_r <= word_i;
         spc_r <= pc_r;
      end
      else if (word_take)
      begin
         dword_r <= word_i;
         dpc_r <= pc_r;
      end
   end

   // Results presented one cycle after the finish state; done and the pointer step last one cycle, the rest hold until the next finish
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         {done_o, inc_we_o, busy_o, word_req_o} <= 4'h0;
         {src_kind_o, dst_kind_o, width_o} <= 6'h0;
         {src_addr_o, src_val_o, dst_addr_o, inc_val_o} <= 80'h0;
         inc_reg_o <= 4'h0;
      end
      else
      begin
         done_o <= (state_r == oad_pkg::OAD_S_FIN) && !check_r;
         busy_o <= !(state_r == oad_pkg::OAD_S_IDLE && !start_take && !check_r) ||
                   (state_r == oad_pkg::OAD_S_FIN);
         word_req_o <= (check_r && route_nxt != oad_pkg::OAD_S_IDLE) ||
                       (!check_r && (state_r == oad_pkg::OAD_S_SRCW ||
                       state_r == oad_pkg::OAD_S_DSTW) && !(word_take &&
                       (state_r == oad_pkg::OAD_S_DSTW || !need_dst)));
         if (state_r == oad_pkg::OAD_S_FIN && !check_r)
         begin
            width_o <= width_r;
            src_kind_o <= skind;
            src_addr_o <= saddr;
            src_val_o <= sval;
            dst_kind_o <= dkind;
            dst_addr_o <= dst_idx;
            // Pointer step only for a general register, never for the generators
            inc_we_o <= (smode_r == oad_pkg::SM_INC) && !cg_hit &&
                        (sreg_r != oad_pkg::REG_PC);
            inc_reg_o <= sreg_r;
            inc_val_o <= sval_r + step;
         end
         else
            inc_we_o <= 1'b0;
      end
   end

   // Result write-back goes to the destination register only
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wb_we_o <= 1'b0;
         wb_reg_o <= 4'h0;
         wb_data_o <= oad_pkg::K_ZERO;
      end
      else
      begin
         wb_we_o <= wb_we_i;
         wb_reg_o <= dreg_r;
         wb_data_o <= wb_shaped;
      end
   end

   // Control and status port; unmapped reads return zero
   logic [31:0] rd_mux;
   assign rd_mux = (addr_i == oad_pkg::OFS_CTRL) ? {31'h0, ctrl_en_r} :
                   (addr_i == oad_pkg::OFS_STAT) ? {15'h0, busy_o, count_r} : 32'h0;
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ctrl_en_r <= oad_pkg::CTRL_RST;
         count_r <= oad_pkg::CNT_RST;
         rdata_r <= 32'h0;
      end
      else
      begin
         if (wr_i && addr_i == oad_pkg::OFS_CTRL)
            ctrl_en_r <= wdata_i[oad_pkg::CTRL_EN];
         count_r <= count_r + {15'h0, done_o};
         rdata_r <= rd_i ? rd_mux : 32'h0;
      end
   end
   assign rdata_o = rdata_r;

   // Checks
   sequence s_fin;
      state_r == oad_pkg::OAD_S_FIN && !check_r;
   endsequence
   sequence s_plain_start;
      start_take && !(source_mode_field_i == oad_pkg::SM_IDX &&
      source_register_i != oad_pkg::REG_CG2) && !(source_mode_field_i == oad_pkg::SM_INC &&
      source_register_i == oad_pkg::REG_PC) && !dest_mode_i;
   endsequence
   a_plain_latency: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_plain_start |-> ##3 done_o) else $error("plain instruction not done in 3 cycles");
   a_pc_words: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_fin |-> pc_r == pc_start_r + {16'h0, words_r, 1'b0})
      else $error("program counter does not match consumed words");
   a_reg_source: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_fin ##0 (smode_r == oad_pkg::SM_REG && !cg_hit) |=> src_kind_o == oad_pkg::OAD_K_REG)
      else $error("register source not reported as register");
   a_ind_pointer: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_fin ##0 (smode_r == oad_pkg::SM_IND && !cg_hit) |=> src_addr_o == $past(sval_r))
      else $error("indirect address is not the register");
   a_inc_step: assert property (@(posedge mclk_i) disable iff (rst_i)
      inc_we_o |-> inc_val_o - src_addr_o == ((width_o == oad_pkg::OAD_W_BYTE) ? 20'h1 :
      (width_o == oad_pkg::OAD_W_WORD) ? 20'h2 : 20'h4)) else $error("autoincrement step wrong");
   a_cg_two: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_fin ##0 (sreg_r == oad_pkg::REG_CG2 && smode_r == oad_pkg::SM_IND) |=>
      src_kind_o == oad_pkg::OAD_K_CONST && src_val_o == 20'h00002)
      else $error("second generator constant wrong");
   a_cg_one: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_fin ##0 (sreg_r == oad_pkg::REG_SR && smode_r == oad_pkg::SM_INC) |=>
      src_val_o == 20'h00008) else $error("first generator constant wrong");
   a_byte_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wb_we_i && width_r == oad_pkg::OAD_W_BYTE && !sign_extend_op_i) |=>
      wb_data_o[19:8] == 12'h000) else $error("byte write left upper bits");
   a_word_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wb_we_i && width_r == oad_pkg::OAD_W_WORD) |=> wb_data_o[19:16] == 4'h0 &&
      wb_data_o[15:0] == $past(wb_data_i[15:0])) else $error("word write shaping wrong");
   a_sxt_fill: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wb_we_i && width_r == oad_pkg::OAD_W_BYTE && sign_extend_op_i) |=>
      wb_data_o[19:8] == {12{$past(wb_data_i[7])}}) else $error("sign extension wrong");
endmodule // oad_decode
`default_nettype wire

// File: design/oad_pkg.sv
// Shared constants and types for the operand addressing decoder
`default_nettype none
package oad_pkg;
   // Datapath widths
   localparam int ADDR_W = 20;
   localparam int WORD_W = 16;
   localparam int REGN_W = 4;
   // Register numbers with special meaning
   localparam logic [3:0] REG_PC = 4'h0;
   localparam logic [3:0] REG_SR = 4'h2;
   localparam logic [3:0] REG_CG2 = 4'h3;
   // Source mode field codes
   localparam logic [1:0] SM_REG = 2'h0;
   localparam logic [1:0] SM_IDX = 2'h1;
   localparam logic [1:0] SM_IND = 2'h2;
   localparam logic [1:0] SM_INC = 2'h3;
   // Extension word field positions
   localparam int EXT_SRC_HI = 10;
   localparam int EXT_SRC_LO = 7;
   localparam int EXT_AL = 6;
   localparam int EXT_DST_HI = 3;
   localparam int EXT_DST_LO = 0;
   // Generated constants
   localparam logic [19:0] K_ZERO = 20'h00000;
   localparam logic [19:0] K_ONE = 20'h00001;
   localparam logic [19:0] K_TWO = 20'h00002;
   localparam logic [19:0] K_FOUR = 20'h00004;
   localparam logic [19:0] K_EIGHT = 20'h00008;
   localparam logic [19:0] K_ONES_B = 20'h000FF;
   localparam logic [19:0] K_ONES_W = 20'h0FFFF;
   localparam logic [19:0] K_ONES_A = 20'hFFFFF;
   // Autoincrement steps and program counter step per code word
   localparam logic [19:0] STEP_B = 20'h00001;
   localparam logic [19:0] STEP_W = 20'h00002;
   localparam logic [19:0] STEP_A = 20'h00004;
   localparam logic [19:0] PC_STEP = 20'h00002;
   // Control and status port
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam int CTRL_EN = 0;
   localparam logic CTRL_RST = 1'b1;
   localparam logic [15:0] CNT_RST = 16'h0000;
   typedef enum logic [1:0] {OAD_W_BYTE, OAD_W_WORD, OAD_W_AWORD} oad_width_e;
   typedef enum logic [1:0] {OAD_K_REG, OAD_K_MEM, OAD_K_CONST} oad_kind_e;
   typedef enum logic [1:0] {OAD_S_IDLE, OAD_S_SRCW, OAD_S_DSTW, OAD_S_FIN} oad_state_e;

   // Operand width from extension presence, length bit and byte/word bit
   function automatic oad_width_e width_of(input logic ext, input logic al, input logic bw);
      if (!ext)
         return bw ? OAD_W_BYTE : OAD_W_WORD;
      else if (!al && bw)
         return OAD_W_AWORD;
      else if (al && bw)
         return OAD_W_BYTE;
      else
         return OAD_W_WORD;
   endfunction
endpackage
`default_nettype wire

// File: design/oad_const_gen.sv
// Constant source decoder for the two generator registers
`default_nettype none
module oad_const_gen (
   input wire logic [3:0] reg_i,
   input wire logic [1:0] mode_i,
   input wire oad_pkg::oad_width_e width_i,
   output logic hit_o,
   output logic [19:0] value_o
);
   logic one_hit;
   logic two_hit;
   logic [19:0] ones;
   logic [19:0] one_val;
   logic [19:0] two_val;

   // All-ones follows the operand width
   assign ones = (width_i == oad_pkg::OAD_W_BYTE) ? oad_pkg::K_ONES_B :
                 (width_i == oad_pkg::OAD_W_WORD) ? oad_pkg::K_ONES_W : oad_pkg::K_ONES_A;
   // Second source: every mode is a constant
   assign two_hit = (reg_i == oad_pkg::REG_CG2);
   assign two_val = (mode_i == oad_pkg::SM_REG) ? oad_pkg::K_ZERO :
                    (mode_i == oad_pkg::SM_IDX) ? oad_pkg::K_ONE :
                    (mode_i == oad_pkg::SM_IND) ? oad_pkg::K_TWO : ones;
   // First source: only the two indirect codes are constants
   assign one_hit = (reg_i == oad_pkg::REG_SR) && mode_i[1];
   assign one_val = mode_i[0] ? oad_pkg::K_EIGHT : oad_pkg::K_FOUR;
   assign hit_o = one_hit || two_hit;
   assign value_o = two_hit ? two_val : (one_hit ? one_val : oad_pkg::K_ZERO);
endmodule // oad_const_gen
`default_nettype wire

// File: design/oad_reg_format.sv
// Register data shaping by operand width, with sign extension
`default_nettype none
module oad_reg_format (
   input wire logic [19:0] data_i,
   input wire oad_pkg::oad_width_e width_i,
   input wire logic sxt_i,
   output logic [19:0] data_o
);
   logic [19:0] byte_val;
   logic [19:0] word_val;

   // Byte results clear the upper bits unless sign extension is asked
   assign byte_val = sxt_i ? {{12{data_i[7]}}, data_i[7:0]} : {12'h000, data_i[7:0]};
   assign word_val = {4'h0, data_i[15:0]};
   assign data_o = (width_i == oad_pkg::OAD_W_BYTE) ? byte_val :
                   (width_i == oad_pkg::OAD_W_WORD) ? word_val : data_i;
endmodule // oad_reg_format
`default_nettype wire

// File: verification/oad_code_mem.sv
// Code memory model: hands out the words that follow an instruction
`default_nettype none
module oad_code_mem (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic word_req_i,
   input wire logic [15:0] w0_i,
   input wire logic [15:0] w1_i,
   input wire logic [3:0] lag_i,
   output logic word_valid_o,
   output logic [15:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idx_r = 1'b0;
   logic [3:0] wait_r = 4'h0;
   // Source word first, then destination word; a late memory waits lag_i cycles
   always @(posedge mclk_i)
   begin
      if (rst_i || start_i)
      begin
         idx_r <= 1'b0;
         wait_r <= 4'h0;
         word_valid_o <= 1'b0;
         word_o <= 16'hFFFF;
      end
      else if (word_valid_o && word_req_i)
      begin
         // Released bus shows the inverse so a stale word never looks right
         word_valid_o <= 1'b0;
         word_o <= ~word_o;
         idx_r <= ~idx_r;
         wait_r <= 4'h0;
      end
      else if (word_req_i && wait_r >= lag_i)
      begin
         word_valid_o <= 1'b1;
         word_o <= idx_r ? w1_i : w0_i;
      end
      else if (word_req_i)
         wait_r <= wait_r + 4'h1;
   end
endmodule // oad_code_mem
`default_nettype wire

// File: verification/test_operand_addressing_decode.sv
// Self-checking bench for the operand addressing decoder
`default_nettype none
module test_operand_addressing_decode;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [3:0] r; logic [1:0] m; logic b; logic [19:0] v;
      logic [15:0] w; logic [1:0] k; logic a; logic [19:0] x;} oad_row_s;
   logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, pc_load_i = 1'b0;
   logic start_i = 1'b0, ext_valid_i = 1'b0, dest_mode_i = 1'b0, byte_word_i = 1'b0;
   logic wb_we_i = 1'b0, sign_extend_op_i = 1'b0, word_valid_i, busy_o, word_req_o, done_o;
   logic inc_we_o, wb_we_o, seen, inc_seen;
   logic [3:0] addr_i = 4'h0, source_register_i = 4'h0, dest_register_i = 4'h6, lag = 4'h0;
   logic [3:0] inc_reg_o, wb_reg_o;
   logic [1:0] source_mode_field_i = 2'h0, width_o, src_kind_o, dst_kind_o;
   logic [15:0] ext_word_i = 16'h0000, word_i, w0 = 16'h0000, w1 = 16'h0000, nd = 16'h0000;
   logic [19:0] pc_load_val_i = 20'h10000, src_reg_val_i = 20'h0, dst_reg_val_i = 20'h15678;
   logic [19:0] wb_data_i = 20'h0, src_addr_o, src_val_o, dst_addr_o, inc_val_o, wb_data_o;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic [19:0] program_counter_o;
   logic [19:0] wbx [3] = '{20'h000DE, 20'h0BCDE, 20'hABCDE};
   int miscompares = 0, compares = 0, n;
   // Register, mode, byte, value, code word, kind (3 = not checked), address?, expected
   oad_row_s rows [15] = '{
      '{4'h5, 2'h0, 1'b0, 20'h12345, 16'h0, 2'h0, 1'b0, 20'h02345},
      '{4'h5, 2'h0, 1'b1, 20'h12345, 16'h0, 2'h0, 1'b0, 20'h00045},
      '{4'h3, 2'h0, 1'b0, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h00000},
      '{4'h3, 2'h1, 1'b0, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h00001},
      '{4'h3, 2'h2, 1'b0, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h00002},
      '{4'h3, 2'h3, 1'b0, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h0FFFF},
      '{4'h3, 2'h3, 1'b1, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h000FF},
      '{4'h2, 2'h0, 1'b0, 20'h12345, 16'h0, 2'h0, 1'b0, 20'h02345},
      '{4'h2, 2'h2, 1'b0, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h00004},
      '{4'h2, 2'h3, 1'b0, 20'h12345, 16'h0, 2'h2, 1'b0, 20'h00008},
      '{4'h2, 2'h1, 1'b0, 20'h12345, 16'h1234, 2'h1, 1'b1, 20'h01234},
      '{4'h5, 2'h1, 1'b0, 20'h23456, 16'h8346, 2'h1, 1'b1, 20'h1B79C},
      '{4'h0, 2'h1, 1'b0, 20'h00000, 16'h0010, 2'h1, 1'b1, 20'h10012},
      '{4'h5, 2'h2, 1'b0, 20'h12340, 16'h0, 2'h1, 1'b1, 20'h12340},
      '{4'h0, 2'h3, 1'b0, 20'h00000, 16'h1234, 2'h2, 1'b0, 20'h01234}};
   always #5 mclk_i = ~mclk_i;
   oad_decode dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pc_load_i,
      .pc_load_val_i, .start_i, .ext_valid_i, .ext_word_i, .source_register_i,
      .source_mode_field_i, .dest_register_i, .dest_mode_i, .byte_word_i, .src_reg_val_i,
      .dst_reg_val_i, .word_valid_i, .word_i, .wb_we_i, .wb_data_i, .sign_extend_op_i, .busy_o,
      .word_req_o, .program_counter_o, .done_o, .width_o, .src_kind_o, .src_addr_o,
      .src_val_o, .dst_kind_o, .dst_addr_o, .inc_we_o, .inc_reg_o, .inc_val_o, .wb_we_o,
      .wb_reg_o, .wb_data_o);
   oad_code_mem mem (.mclk_i, .rst_i, .start_i, .word_req_i(word_req_o), .w0_i(w0),
      .w1_i(w1), .lag_i(lag), .word_valid_o(word_valid_i), .word_o(word_i));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Register port: one-cycle strobes, read data looked at in the following cycle only
   task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= w;
      rd_i <= !w;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
      if (!w)
         chk("rdata", d, rdata_o);
   endtask
   // One instruction: fields beside a start pulse, then a bounded wait for done
   task automatic go(input logic [3:0] r, input logic [1:0] m, input logic b, input logic e,
      input logic [19:0] v, input logic dm);
      @(posedge mclk_i);
      {source_register_i, source_mode_field_i, byte_word_i} <= {r, m, b};
      {ext_valid_i, src_reg_val_i, dest_mode_i, start_i} <= {e, v, dm, 1'b1};
      @(posedge mclk_i);
      start_i <= 1'b0;
      seen = 1'b0;
      for (int k = 0; k < 60 && !seen; k++)
      begin
         @(posedge mclk_i);
         #1;
         seen = (done_o === 1'b1);
         inc_seen = inc_we_o;
      end
      nd = nd + 16'h1;
      chk("done", 1, seen);
   endtask
   // Result write to the destination, shaped by the width of the last decode
   task automatic wb(input logic [19:0] d, input logic s, input logic [19:0] ex);
      @(posedge mclk_i);
      {wb_we_i, wb_data_i, sign_extend_op_i} <= {1'b1, d, s};
      @(posedge mclk_i);
      wb_we_i <= 1'b0;
      #1 chk("wb", {1'b1, 4'h6, ex}, {wb_we_o, wb_reg_o, wb_data_o});
   endtask
   // Watchdog: whole run needs well under 5000 cycles
   initial
   begin
      #50us;
      miscompares++;
      stop_test;
   end
   initial
   begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1 chk("reset outs", 0, {busy_o, done_o, word_req_o, inc_we_o, wb_we_o});
      chk("reset rdata", 0, rdata_o);
      chk("reset pc", 0, program_counter_o);
      rw(1'b0, 4'h0, 32'h1);
      rw(1'b0, 4'h8, 32'h0);
      foreach (rows[i])
      begin
         @(posedge mclk_i);
         pc_load_i <= 1'b1;
         @(posedge mclk_i);
         pc_load_i <= 1'b0;
         w0 = rows[i].w;
         go(rows[i].r, rows[i].m, rows[i].b, 1'b0, rows[i].v, 1'b0);
         if (rows[i].k != 2'h3)
            chk("src kind", rows[i].k, src_kind_o);
         chk("src", rows[i].x, rows[i].a ? src_addr_o : src_val_o);
         chk("dst kind", 0, dst_kind_o);
         $display("row %0d finished", i);
      end
      chk("pc", 20'h10004, program_counter_o);
      // Autoincrement steps and result shaping for byte, word and address-word
      for (n = 0; n < 3; n++)
      begin
         go(4'h5, 2'h3, n != 1, n == 2, 20'h12340, 1'b0);
         chk("width", n, width_o);
         chk("inc", {1'b1, 4'h5, 20'h12340 + (20'h1 << n)}, {inc_seen, inc_reg_o, inc_val_o});
         wb(20'hABCDE, 1'b0, wbx[n]);
      end
      go(4'h5, 2'h0, 1'b1, 1'b0, 20'h00080, 1'b0);
      wb(20'h00080, 1'b1, 20'hFFF80);
      $display("widths finished");
      // Indexed source and destination together, with a late code memory
      {w0, w1, lag} = {16'h8346, 16'h2100, 4'h3};
      go(4'h5, 2'h1, 1'b0, 1'b0, 20'h23456, 1'b1);
      chk("pair src", 20'h1B79C, src_addr_o);
      chk("pair dst", {2'h1, 20'h17778}, {dst_kind_o, dst_addr_o});
      // Extension nibble prefixes the index
      {w0, lag} = {16'h2346, 4'h0};
      ext_word_i <= 16'h0080;
      go(4'h5, 2'h1, 1'b0, 1'b1, 20'h23456, 1'b0);
      chk("ext src", 20'h3579C, src_addr_o);
      $display("pairing finished");
      // Disabled decoder ignores a start; count of dones matches
      rw(1'b1, 4'h0, 32'h0);
      @(posedge mclk_i);
      start_i <= 1'b1;
      @(posedge mclk_i);
      start_i <= 1'b0;
      seen = 1'b0;
      repeat (10) @(posedge mclk_i) seen = seen | (done_o === 1'b1);
      chk("refused", 0, seen);
      rw(1'b0, 4'h4, {16'h0000, nd});
      rw(1'b1, 4'h0, 32'h1);
      $display("port finished");
      stop_test;
   end
endmodule // test_operand_addressing_decode
`default_nettype wire
